//--- src/wdpt_map.svh
// Function
// - the watchdog runs only while enabled, and enabling it also switches on the internal RC oscillator source.
// - the base counter divides the oscillator tick down to a nominal 4 ms period.
// - the base period drives a 16-bit postscaler, and a configuration-driven multiplexer picks the tap that times out.
// - the selectable timeout runs from 4 ms to 131.072 s, in power-of-two steps of the base period.
// - the clear-watchdog and power-down instructions reset both the base count and the postscaler to zero.
// - any change of the oscillator frequency select field clears both counts.
// - a detected clock failure clears both counts.
// - a software enable bit turns the watchdog on only while the configuration enable bit leaves it off.
`ifndef WDPT_MAP_SVH
`define WDPT_MAP_SVH
`define WDPT_CLK_HZ 10000000
`define WDPT_BASE_PERIOD_US 4000
`define WDPT_BASE_CYCLES ((`WDPT_CLK_HZ / 1000000) * `WDPT_BASE_PERIOD_US)
`define WDPT_BASE_W 16
`define WDPT_POST_W 16
`define WDPT_SEL_W 4
`define WDPT_INTERNAL_OSC_FREQUENCY_SELECT_W 3
`define WDPT_BASE_RST 16'h0000
`define WDPT_POST_RST 16'h0000
`define WDPT_INTERNAL_OSC_FREQUENCY_SELECT_RST 3'h0
`endif

//--- src/wdpt_pkg.sv
package wdpt_pkg;
   typedef enum logic [1:0] {
      WDPT_OFF,
      WDPT_RUN,
      WDPT_SLEEP
   } wdpt_mode_t;

   typedef struct packed {
      logic clearInstr;
      logic sleepInstr;
      logic wakeEvent;
      logic clockFail;
   } wdpt_evt_t;

   typedef struct packed {
      logic cfgEnable;
      logic [3:0] postSelect;
      logic [2:0] intOscFreqSelect;
   } wdpt_cfg_t;
endpackage

//--- src/wdpt_base_div.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdpt_map.svh"
module wdpt_base_div (
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   input wire logic clearCount,
   output logic baseTick
);
   typedef struct packed {
      logic [`WDPT_BASE_W-1:0] count;
      logic tick;
   } wdpt_div_st_t;

   localparam logic [`WDPT_BASE_W-1:0] LastCount = `WDPT_BASE_W'(`WDPT_BASE_CYCLES - 1);

   wdpt_div_st_t st_q;
   wdpt_div_st_t st_d;

   ////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      st_d.tick = 1'b0;
      if (clearCount || !run) begin
         st_d.count = `WDPT_BASE_RST;
      end else if (st_q.count == LastCount) begin
         st_d.count = `WDPT_BASE_RST;
         st_d.tick = 1'b1;
      end else begin
         st_d.count = st_q.count + `WDPT_BASE_W'(1);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign baseTick = st_q.tick;
endmodule
`default_nettype wire

//--- src/wdpt_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdpt_map.svh"
module wdpt_top (
   input wire logic clk,
   input wire logic reset,
   input wire wdpt_pkg::wdpt_cfg_t cfg,
   input wire wdpt_pkg::wdpt_evt_t evt,
   input wire logic swEnableWrite,
   input wire logic swEnableData,
   output logic swEnable,
   output logic watchdogOn,
   output logic intRcOscRequest,
   output logic timeoutReset,
   output logic timeoutWake,
   output logic [`WDPT_POST_W-1:0] postCount
);
   typedef struct packed {
      wdpt_pkg::wdpt_mode_t mode;
      logic swEn;
      logic [`WDPT_INTERNAL_OSC_FREQUENCY_SELECT_W-1:0] ircfSeen;
      logic [`WDPT_POST_W-1:0] post;
      logic rstPulse;
      logic wakePulse;
      logic on;
   } wdpt_top_st_t;

   wdpt_top_st_t st_q;
   wdpt_top_st_t st_d;
   logic enabled;
   logic clearAll;
   logic baseTick;
   logic tapHit;

   // true once the chosen tap of the incremented count rolls over to zero
   function automatic logic tap_done(input logic [`WDPT_POST_W-1:0] cnt, input logic [`WDPT_SEL_W-1:0] sel);
      logic [`WDPT_POST_W-1:0] mask;
      mask = (`WDPT_POST_W'(1) << sel) - `WDPT_POST_W'(1);
      tap_done = ((cnt & mask) == mask);
   endfunction

   ////////////////////////////////////////////////////////////////
   assign enabled = cfg.cfgEnable | st_q.swEn;
   assign clearAll = evt.clearInstr | evt.sleepInstr | evt.clockFail
      | (cfg.intOscFreqSelect != st_q.ircfSeen);
   assign tapHit = baseTick & tap_done(st_q.post, cfg.postSelect);

   wdpt_base_div u_base (
      .clk(clk),
      .reset(reset),
      .run(enabled),
      .clearCount(clearAll),
      .baseTick(baseTick)
   );

   ////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      st_d.rstPulse = 1'b0;
      st_d.wakePulse = 1'b0;
      st_d.ircfSeen = cfg.intOscFreqSelect;
      // software bit is stored always but only matters when config leaves it off
      if (swEnableWrite) begin
         st_d.swEn = swEnableData;
      end
      if (!enabled) begin
         st_d.mode = wdpt_pkg::WDPT_OFF;
         st_d.post = `WDPT_POST_RST;
      end else if (clearAll) begin
         st_d.post = `WDPT_POST_RST;
         st_d.mode = evt.sleepInstr ? wdpt_pkg::WDPT_SLEEP : wdpt_pkg::WDPT_RUN;
      end else begin
         case (st_q.mode)
            wdpt_pkg::WDPT_OFF: begin
               st_d.mode = wdpt_pkg::WDPT_RUN;
            end
            wdpt_pkg::WDPT_RUN, wdpt_pkg::WDPT_SLEEP: begin
               if (st_q.mode == wdpt_pkg::WDPT_SLEEP && evt.wakeEvent) begin
                  st_d.mode = wdpt_pkg::WDPT_RUN;
               end
               if (tapHit) begin
                  st_d.post = `WDPT_POST_RST;
                  // a timeout in power-down wakes instead of resetting
                  if (st_q.mode == wdpt_pkg::WDPT_SLEEP) begin
                     st_d.wakePulse = 1'b1;
                     st_d.mode = wdpt_pkg::WDPT_RUN;
                  end else begin
                     st_d.rstPulse = 1'b1;
                  end
               end else if (baseTick) begin
                  st_d.post = st_q.post + `WDPT_POST_W'(1);
               end
            end
            default: begin
               st_d.mode = wdpt_pkg::WDPT_OFF;
            end
         endcase
      end
      // registered copy of the mode test, so the status pins come straight from a flop
      st_d.on = (st_d.mode != wdpt_pkg::WDPT_OFF);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q <= '{mode: wdpt_pkg::WDPT_OFF, swEn: 1'b0, ircfSeen: `WDPT_INTERNAL_OSC_FREQUENCY_SELECT_RST,
                   post: `WDPT_POST_RST, rstPulse: 1'b0, wakePulse: 1'b0, on: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   assign swEnable = st_q.swEn;
   assign watchdogOn = st_q.on;
   assign intRcOscRequest = st_q.on;
   assign timeoutReset = st_q.rstPulse;
   assign timeoutWake = st_q.wakePulse;
   assign postCount = st_q.post;
endmodule
`default_nettype wire

//--- dv/wdpt_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdpt_map.svh"
module wdpt_properties (
   input wire logic clk,
   input wire logic reset,
   input wire wdpt_pkg::wdpt_cfg_t cfg,
   input wire wdpt_pkg::wdpt_evt_t evt,
   input wire logic swEnableWrite,
   input wire logic swEnableData,
   input wire logic swEnable,
   input wire logic watchdogOn,
   input wire logic intRcOscRequest,
   input wire logic timeoutReset,
   input wire logic timeoutWake,
   input wire logic [`WDPT_POST_W-1:0] postCount
);
////////////////////////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (reset);
property p_osc; intRcOscRequest == watchdogOn; endproperty
a_osc: assert property (p_osc) else $error("osc request differs");
property p_clr; evt.clearInstr || evt.sleepInstr |=> postCount == 16'h0000; endproperty
a_clr: assert property (p_clr) else $error("clear missed");
property p_frq; cfg.intOscFreqSelect != $past(cfg.intOscFreqSelect) |=> postCount == 16'h0000; endproperty
a_frq: assert property (p_frq) else $error("freq change missed");
property p_cf; evt.clockFail |=> postCount == 16'h0000; endproperty
a_cf: assert property (p_cf) else $error("clock fail missed");
property p_sw; swEnableWrite |=> swEnable == $past(swEnableData); endproperty
a_sw: assert property (p_sw) else $error("sw enable write lost");
property p_on; $rose(watchdogOn) |-> $past(cfg.cfgEnable | swEnable); endproperty
a_on: assert property (p_on) else $error("watchdog on without enable");
property p_to; timeoutReset || timeoutWake |=> !(timeoutReset || timeoutWake); endproperty
a_to: assert property (p_to) else $error("timeout pulse too long");
// postscaler only steps by one or restarts
property p_post; $changed(postCount) |-> postCount == 16'h0000 || postCount == $past(postCount) + 16'h0001;
endproperty
a_post: assert property (p_post) else $error("postscaler jump");
endmodule
bind wdpt_top wdpt_properties i_wdpt_properties (.clk, .reset, .cfg, .evt, .swEnableWrite, .swEnableData,
   .swEnable, .watchdogOn, .intRcOscRequest, .timeoutReset, .timeoutWake, .postCount);
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdpt_map.svh"
module testbench;
logic clk = 0, reset = 1, swEnableWrite = 0, swEnableData = 0;
wdpt_pkg::wdpt_cfg_t cfg = '0;
wdpt_pkg::wdpt_evt_t evt = '0;
logic swEnable, watchdogOn, intRcOscRequest, timeoutReset, timeoutWake;
logic [`WDPT_POST_W-1:0] postCount;
int err_count = 0, checks = 0, cyc = 0, n;
always #50 clk = ~clk;
wdpt_top i_wdpt_top (.clk(clk), .reset(reset), .cfg(cfg), .evt(evt), .swEnableWrite(swEnableWrite),
   .swEnableData(swEnableData), .swEnable(swEnable), .watchdogOn(watchdogOn),
   .intRcOscRequest(intRcOscRequest), .timeoutReset(timeoutReset), .timeoutWake(timeoutWake),
   .postCount(postCount));
////////////////////////////////////////////////////////////
// 4 ms at 10 MHz, plus the one-cycle tick latency
function int expPeriod(input int sel);
   return 40000 * (1 << sel) + 1;
endfunction
task chk(input logic [15:0] got, input logic [15:0] exp);
   checks++;
   if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
   end
endtask
task sw(input logic d);
   swEnableData = d;
   swEnableWrite = 1;
   @(negedge clk);
   swEnableWrite = 0;
   repeat (2) @(negedge clk);
   chk(swEnable, d);
endtask
// bounded wait, so a dead divider cannot hang the run
task waitTo(input logic wake);
   n = 0;
   while (n < 50000 && !(wake ? timeoutWake : timeoutReset)) begin
      @(negedge clk);
      n++;
   end
   chk(16'(n > expPeriod(0) - 3 && n < expPeriod(0) + 3), 16'h0001);
   @(negedge clk);
   chk({timeoutReset, timeoutWake}, 16'h0000);
endtask
task tally_and_finish();
   $display("errors=%0d checks=%0d", err_count, checks);
   if (err_count == 0 && checks > 0) $display("bench passed");
   else $display("bench failed");
   $finish;
endtask
always @(posedge clk) begin
   cyc++;
   if (cyc == 90000) begin
      err_count++;
      tally_and_finish();
   end
end
initial begin
   n = $urandom(32'hAE82);
   cfg.intOscFreqSelect = 3'h5;
   repeat (4) @(negedge clk);
   reset = 0;
   sw(1);
   chk({watchdogOn, intRcOscRequest}, 16'h0003);
   sw(0);
   chk(watchdogOn, 0);
   cfg.cfgEnable = 1;
   sw(0);
   chk(watchdogOn, 1);
   repeat (300) begin
      @(negedge clk);
      evt = ($urandom % 6 == 0) ? wdpt_pkg::wdpt_evt_t'(4'($urandom)) : '0;
      cfg.postSelect = 4'($urandom);
      if ($urandom % 20 == 0) cfg.intOscFreqSelect = 3'($urandom);
   end
   cfg.postSelect = 0;
   evt = '0;
   evt.clearInstr = 1;
   evt.wakeEvent = 1;
   @(negedge clk);
   evt = '0;
   waitTo(0);
   evt.sleepInstr = 1;
   @(negedge clk);
   evt = '0;
   chk(postCount, 0);
   waitTo(1);
   tally_and_finish();
end
endmodule
`default_nettype wire
